// ===== rtl/afs_pkg.sv
// afs_pkg: shared constants and types for the amplifier fault supervisor
package afs_pkg;
    // ***************************************************
    // timing
    // ***************************************************
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int OVERLOAD_TIME_US = 1250;             // overload counter, 1.25 ms
    localparam int OVERLOAD_CYCLES = OVERLOAD_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int RELEASE_HOLD_MS = 1000;              // least wait before clearing overload
    localparam longint RELEASE_HOLD_CYCLES = longint'(RELEASE_HOLD_MS) * (CLK_FREQ_HZ / 1000);
    localparam int RESET_PULSE_CYCLES = 16;             // controller reset pulse width
    // ***************************************************
    // counts and reset values
    // ***************************************************
    localparam int NUM_BRIDGES = 6;
    localparam logic STAGE_EN_RESET = 1'b0;
    localparam logic PIN_HIGH = 1'b1;
    // ***************************************************
    // controller register map (byte addresses)
    // ***************************************************
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;   // bit0 hold reset low, bit1 clear req
    localparam logic [31:0] REG_STATUS = 32'h0000_0004; // bit0 fault, bit1 warn, bit2 wait done
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int STAT_FAULT_BIT = 0;
    localparam int STAT_WARN_BIT = 1;
    localparam int STAT_READY_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef enum logic [1:0] {
        AFS_RUN = 2'b00,
        AFS_LIMIT = 2'b01,
        AFS_LATCHED = 2'b11
    } afs_state_type;
endpackage : afs_pkg

// ===== rtl/afs_link_if.sv
// afs_link_if: fault lines and reset between supervisor and controller
`timescale 1ns/100ps
interface afs_link_if;
    logic reset_n;              // controller drives, active low
    logic shutdown_fault_n_o;   // device pulls low
    logic shutdown_fault_n_oe;
    logic overtemp_warn_n_o;
    logic overtemp_warn_n_oe;
    // open-drain wires with pull-up
    logic shutdown_fault_n;
    logic overtemp_warn_n;
    assign shutdown_fault_n = (shutdown_fault_n_oe && !shutdown_fault_n_o) ? 1'b0 : 1'b1;
    assign overtemp_warn_n = (overtemp_warn_n_oe && !overtemp_warn_n_o) ? 1'b0 : 1'b1;
    modport device (input reset_n, output shutdown_fault_n_o, output shutdown_fault_n_oe,
        output overtemp_warn_n_o, output overtemp_warn_n_oe);
    modport host (output reset_n, input shutdown_fault_n, input overtemp_warn_n);
endinterface : afs_link_if

// ===== rtl/afs_sync3.sv
// afs_sync3: three-flop synchroniser accepting a change when stages two and three agree
`timescale 1ns/100ps
module afs_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    // ***************************************************
    // shift chain
    // ***************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
        end else if (clk_en) begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end
    // per-bit agreement filter
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync_out[i] <= INIT[i];
                end else if (clk_en && (stage2[i] == stage3[i])) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule : afs_sync3

// ===== rtl/afs_device.sv
// afs_device: fault supervisor logic of the power stage
// Operation
// - outputs hi-z until both supplies good
// - controller should hold reset during ramp
// - fully operational while supplies above threshold
// - controller should hold reset during power-down
// - fault lines are active-low open-drain
// - shutdown line low on any shutdown fault
// - warning line low above warning comparator
// - two-line status encoding as tabled
// - reset low releases both fault lines
// - controller should react to warning
// - any fault: hi-z and shutdown low
// - auto recovery except latched overload
// - controller clears overload after one second
// - overcurrent limits current first
// - persistent overcurrent latches overload shutdown
// - temperature error forces thermal shutdown
// - each transistor detector monitored independently
// - reset rising edge clears overload latch
// - reset low forces all bridges hi-z
// - overload counter times persistent overcurrent
`timescale 1ns/100ps
module afs_device #(
    parameter int NUM_BRIDGES = afs_pkg::NUM_BRIDGES,
    parameter int OVERLOAD_CYCLES = afs_pkg::OVERLOAD_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    afs_link_if.device link,
    input wire logic gate_supply_ok,
    input wire logic common_supply_ok,
    input wire logic overtemp_warn,
    input wire logic overtemp_error,
    input wire logic [NUM_BRIDGES-1:0] oc_high,
    input wire logic [NUM_BRIDGES-1:0] oc_low,
    output logic [NUM_BRIDGES-1:0] bridge_enable,
    output logic current_limit,
    output logic overload_latch,
    output logic supply_undervolt
);
    import afs_pkg::*;

    localparam int IN_W = 5 + 2 * NUM_BRIDGES;
    localparam int CNT_W = $clog2(OVERLOAD_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(OVERLOAD_CYCLES - 1);

    logic [IN_W-1:0] raw_in;
    logic [IN_W-1:0] sync_in;
    logic gate_ok_s;
    logic common_ok_s;
    logic warn_s;
    logic error_s;
    logic reset_n_s;
    logic reset_n_d;
    logic [NUM_BRIDGES-1:0] oc_high_s;
    logic [NUM_BRIDGES-1:0] oc_low_s;
    logic any_oc;
    logic undervolt;
    logic shutdown;
    afs_state_type state;
    logic [CNT_W-1:0] ol_count;

    // ***************************************************
    // input synchronisation
    // ***************************************************
    assign raw_in = {link.reset_n, gate_supply_ok, common_supply_ok, overtemp_warn,
        overtemp_error, oc_high, oc_low};
    // supplies start bad, reset starts asserted
    afs_sync3 #(.WIDTH(IN_W), .INIT('0)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .async_in(raw_in),
        .sync_out(sync_in)
    );
    assign {reset_n_s, gate_ok_s, common_ok_s, warn_s, error_s, oc_high_s, oc_low_s} = sync_in;

    // ***************************************************
    // fault decode
    // ***************************************************
    // each detector of every transistor feeds the same or-tree
    assign any_oc = |{oc_high_s, oc_low_s};
    // both supplies monitored independently
    assign undervolt = !(gate_ok_s && common_ok_s);
    // self-recovering faults plus latched overload
    assign shutdown = undervolt || error_s || (state == AFS_LATCHED);

    // reset edge tracker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_n_d <= 1'b0;
        end else if (clk_en) begin
            reset_n_d <= reset_n_s;
        end
    end

    // ***************************************************
    // overload state machine
    // ***************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= AFS_RUN;
            ol_count <= '0;
        end else if (clk_en) begin
            case (state)
                AFS_RUN: begin
                    ol_count <= '0;
                    if (any_oc && reset_n_s && !undervolt) begin
                        state <= AFS_LIMIT;
                    end
                end
                AFS_LIMIT: begin
                    if (!any_oc || !reset_n_s) begin
                        state <= AFS_RUN;
                        ol_count <= '0;
                    end else if (ol_count == CNT_LAST) begin
                        state <= AFS_LATCHED;
                    end else begin
                        ol_count <= ol_count + 1'b1;
                    end
                end
                AFS_LATCHED: begin
                    ol_count <= '0;
                    if (reset_n_s && !reset_n_d) begin
                        state <= AFS_RUN;
                    end
                end
                default: begin
                    state <= AFS_RUN;
                    ol_count <= '0;
                end
            endcase
        end
    end

    // ***************************************************
    // power stage and status outputs
    // ***************************************************
    // bridges run only when reset high and no shutdown
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bridge_enable <= {NUM_BRIDGES{STAGE_EN_RESET}};
            current_limit <= 1'b0;
            overload_latch <= 1'b0;
            supply_undervolt <= 1'b0;
        end else if (clk_en) begin
            bridge_enable <= {NUM_BRIDGES{reset_n_s && !shutdown}};
            current_limit <= (state == AFS_LIMIT) && any_oc;
            overload_latch <= (state == AFS_LATCHED);
            supply_undervolt <= undervolt;
        end
    end

    // open-drain fault lines; drive low only, reset releases both
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.shutdown_fault_n_o <= 1'b0;
            link.shutdown_fault_n_oe <= 1'b0;
            link.overtemp_warn_n_o <= 1'b0;
            link.overtemp_warn_n_oe <= 1'b0;
        end else if (clk_en) begin
            link.shutdown_fault_n_o <= 1'b0;
            link.overtemp_warn_n_o <= 1'b0;
            link.shutdown_fault_n_oe <= reset_n_s && shutdown;
            link.overtemp_warn_n_oe <= reset_n_s && (warn_s || error_s);
        end
    end
endmodule : afs_device

// ===== rtl/afs_host.sv
// afs_host: controller end, AHB-Lite slave driving the supervisor reset line
`timescale 1ns/100ps
module afs_host #(
    parameter longint RELEASE_HOLD_CYCLES = afs_pkg::RELEASE_HOLD_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    afs_link_if.host link,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import afs_pkg::*;

    logic [2:0] fault_s;
    logic [2:0] warn_s;
    logic hold_reset;
    logic pulse_busy;
    logic [7:0] pulse_cnt;
    logic [39:0] since_fault;
    logic wait_done;
    logic wr_pend;
    logic rd_pend;
    logic [31:0] addr_q;
    logic reset_drv;

    // ***************************************************
    // pin sampling, three flops, accept on agreement
    // ***************************************************
    logic fault_f;
    logic warn_f;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_s <= 3'h7;
            warn_s <= 3'h7;
            fault_f <= 1'b1;
            warn_f <= 1'b1;
        end else if (clk_en) begin
            fault_s <= {fault_s[1:0], link.shutdown_fault_n};
            warn_s <= {warn_s[1:0], link.overtemp_warn_n};
            if (fault_s[1] == fault_s[2]) begin
                fault_f <= fault_s[2];
            end
            if (warn_s[1] == warn_s[2]) begin
                warn_f <= warn_s[2];
            end
        end
    end

    // time since shutdown went low, for the one second wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_fault <= '0;
        end else if (clk_en) begin
            if (fault_f) begin
                since_fault <= '0;
            end else if (!wait_done) begin
                since_fault <= since_fault + 1'b1;
            end
        end
    end
    assign wait_done = (since_fault >= 40'(RELEASE_HOLD_CYCLES));

    // ***************************************************
    // AHB-Lite slave, zero wait states
    // ***************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= '0;
        end else if (clk_en && hready) begin
            wr_pend <= hsel && (htrans == HTRANS_NONSEQ) && hwrite;
            rd_pend <= hsel && (htrans == HTRANS_NONSEQ) && !hwrite;
            addr_q <= haddr;
        end
    end

    // control register and reset pulse; clear refused while shutdown line low until wait done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_reset <= CTRL_RESET[CTRL_HOLD_BIT];
            pulse_busy <= 1'b0;
            pulse_cnt <= '0;
        end else if (clk_en) begin
            if (wr_pend && addr_q == REG_CTRL) begin
                hold_reset <= hwdata[CTRL_HOLD_BIT];
                if (hwdata[CTRL_CLEAR_BIT] && (fault_f || wait_done)) begin
                    pulse_busy <= 1'b1;
                    pulse_cnt <= '0;
                end
            end
            if (pulse_busy) begin
                pulse_cnt <= pulse_cnt + 1'b1;
                if (pulse_cnt == 8'(RESET_PULSE_CYCLES - 1)) begin
                    pulse_busy <= 1'b0;
                end
            end
        end
    end

    // outputs straight from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_drv <= 1'b0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            reset_drv <= !(hold_reset || pulse_busy);
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
                if (haddr == REG_CTRL) begin
                    hrdata <= {31'h0000_0000, hold_reset};
                end else if (haddr == REG_STATUS) begin
                    // warning visible to software
                    hrdata <= {29'h0000_0000, wait_done, !warn_f, !fault_f};
                end else begin
                    hrdata <= '0;
                end
            end
        end
    end
    assign link.reset_n = reset_drv;
endmodule : afs_host

// ===== verification/afs_link_sva.sv
// afs_link_sva: assertions on the fault lines, reset line and supervisor ports
`timescale 1ns/100ps
module afs_link_sva #(
    parameter int NUM_BRIDGES = 6,
    parameter int OVERLOAD_CYCLES = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic reset_n,
    input wire logic shutdown_fault_n,
    input wire logic overtemp_warn_n,
    input wire logic gate_supply_ok,
    input wire logic common_supply_ok,
    input wire logic overtemp_warn,
    input wire logic overtemp_error,
    input wire logic [NUM_BRIDGES-1:0] oc_high,
    input wire logic [NUM_BRIDGES-1:0] oc_low,
    input wire logic [NUM_BRIDGES-1:0] bridge_enable,
    input wire logic current_limit,
    input wire logic overload_latch
);
    int oc_cnt;
    logic [3:0] rst_hi_cnt;
    logic oc_any;
    logic all_ok;
    // any detector tripped, and supplies and temperature all good
    assign oc_any = |{oc_high, oc_low};
    assign all_ok = gate_supply_ok && common_supply_ok && !overtemp_warn && !overtemp_error;
    // consecutive overcurrent cycles while the reset line is released
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oc_cnt <= 0;
        end else begin
            oc_cnt <= (reset_n && oc_any) ? ((oc_cnt < 1000) ? oc_cnt + 1 : oc_cnt) : 0;
        end
    end
    // cycles since the reset line rose, saturating at 15
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_hi_cnt <= 4'h0;
        end else begin
            rst_hi_cnt <= !reset_n ? 4'h0 : ((rst_hi_cnt == 4'hf) ? rst_hi_cnt : rst_hi_cnt + 4'h1);
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ***************************************************
    // fault line properties
    // ***************************************************
    sequence s_run;
        (reset_n && all_ok && !oc_any && !overload_latch) [*8];
    endsequence
    sequence s_oc_start;
        $rose(oc_any) ##0 (reset_n && all_ok && oc_any && !overload_latch) [*8];
    endsequence
    sequence s_reset_pulse;
        (!reset_n) [*8] ##1 reset_n [*8];
    endsequence
    property p_normal;
        s_run |-> shutdown_fault_n && overtemp_warn_n && bridge_enable == '1;
    endproperty
    property p_warn;
        (reset_n && overtemp_warn && !overtemp_error && gate_supply_ok && common_supply_ok
            && !oc_any && !overload_latch) [*8] |-> !overtemp_warn_n && shutdown_fault_n;
    endproperty
    property p_uv;
        (reset_n && !(gate_supply_ok && common_supply_ok) && !overtemp_warn && !overtemp_error)
            [*8] |-> !shutdown_fault_n && overtemp_warn_n && bridge_enable == '0;
    endproperty
    property p_thermal;
        (reset_n && overtemp_error) [*8] |-> !shutdown_fault_n && !overtemp_warn_n
            && bridge_enable == '0;
    endproperty
    property p_release;
        (!reset_n) [*8] |-> shutdown_fault_n && overtemp_warn_n && bridge_enable == '0;
    endproperty
    property p_limit;
        s_oc_start |-> current_limit && shutdown_fault_n;
    endproperty
    property p_latch;
        oc_cnt == OVERLOAD_CYCLES + 12 |-> overload_latch && !shutdown_fault_n
            && bridge_enable == '0;
    endproperty
    property p_not_early;
        $rose(overload_latch) |-> oc_cnt >= OVERLOAD_CYCLES;
    endproperty
    property p_hold;
        overload_latch && rst_hi_cnt == 4'hf |=> overload_latch;
    endproperty
    property p_clear;
        s_reset_pulse |-> !overload_latch;
    endproperty
    property p_sync;
        $fell(common_supply_ok) && shutdown_fault_n |=> shutdown_fault_n [*2];
    endproperty
    a_normal: assert property (p_normal) else $error("fault lines low in normal run");
    a_warn: assert property (p_warn) else $error("warning line not low alone");
    a_uv: assert property (p_uv) else $error("undervoltage not reported");
    a_thermal: assert property (p_thermal) else $error("thermal shutdown missing");
    a_release: assert property (p_release) else $error("reset low not releasing");
    a_limit: assert property (p_limit) else $error("no current limit phase");
    a_latch: assert property (p_latch) else $error("overload not latched");
    a_not_early: assert property (p_not_early) else $error("overload latched early");
    a_hold: assert property (p_hold) else $error("overload latch dropped");
    a_clear: assert property (p_clear) else $error("reset pulse left latch set");
    a_sync: assert property (p_sync) else $error("input used unsynchronised");
endmodule : afs_link_sva

// ===== verification/amp_fault_supervisor_tb.sv
// amp_fault_supervisor_tb: supervisor and controller joined over the link
`timescale 1ns/100ps
module amp_fault_supervisor_tb;
    import afs_pkg::*;
    localparam int OL_CYC = 20;
    localparam int HOLD_CYC = 100;              // longer than the refused-clear window below
    logic hclk, hresetn, clk_en, gate_supply_ok, common_supply_ok, overtemp_warn, overtemp_error;
    logic [NUM_BRIDGES-1:0] oc_high, oc_low, bridge_enable;
    logic current_limit, overload_latch, hsel, hwrite, hready, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int error_cnt, total_checks;
    logic [3:0] in_tab [6] = '{4'he, 4'hd, 4'h4, 4'h8, 4'h1, 4'ha};
    logic [1:0] pin_tab [6] = '{2'h2, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};
    afs_link_if link ();
    assign hready = hreadyout;
    afs_device #(.OVERLOAD_CYCLES(OL_CYC)) u_afs_device (.hclk(hclk), .hresetn(hresetn),
        .clk_en(clk_en), .link(link), .gate_supply_ok(gate_supply_ok),
        .common_supply_ok(common_supply_ok), .overtemp_warn(overtemp_warn),
        .overtemp_error(overtemp_error), .oc_high(oc_high), .oc_low(oc_low),
        .bridge_enable(bridge_enable), .current_limit(current_limit),
        .overload_latch(overload_latch), .supply_undervolt());
    afs_host #(.RELEASE_HOLD_CYCLES(HOLD_CYC)) u_afs_host (.hclk(hclk), .hresetn(hresetn),
        .clk_en(clk_en), .link(link), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp());
    afs_link_sva #(.NUM_BRIDGES(NUM_BRIDGES), .OVERLOAD_CYCLES(OL_CYC)) u_afs_link_sva (
        .hclk(hclk), .hresetn(hresetn), .reset_n(link.reset_n),
        .shutdown_fault_n(link.shutdown_fault_n), .overtemp_warn_n(link.overtemp_warn_n),
        .gate_supply_ok(gate_supply_ok), .common_supply_ok(common_supply_ok),
        .overtemp_warn(overtemp_warn), .overtemp_error(overtemp_error), .oc_high(oc_high),
        .oc_low(oc_low), .bridge_enable(bridge_enable), .current_limit(current_limit),
        .overload_latch(overload_latch));
    // ***************************************************
    // tasks
    // ***************************************************
    task automatic cycles(input int n);
        repeat (n) @(posedge hclk);
    endtask : cycles
    // one single word transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word
    // compares both fault lines and the bridge enables in one go
    task automatic check_out(input logic [NUM_BRIDGES+1:0] exp);
        check_word({link.shutdown_fault_n, link.overtemp_warn_n, bridge_enable}, exp);
    endtask : check_out
    task automatic read_chk(input logic [31:0] addr, input logic [31:0] exp, input logic [31:0] m);
        ahb(1'b0, addr, 32'h0000_0000);
        check_word(rd & m, exp);
    endtask : read_chk
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // clock and watchdog
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial begin
        #40000;
        error_cnt++;
        $display("unexpected timeout at %0t", $time);
        test_done();
    end
    // ***************************************************
    // main sequence
    // ***************************************************
    initial begin
        {hresetn, gate_supply_ok, common_supply_ok, overtemp_warn, hsel, hwrite} = '0;
        {clk_en, overtemp_error} = 2'h3;
        {oc_high, oc_low, haddr, hwdata, htrans, hsize} = '0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        read_chk(REG_CTRL, CTRL_RESET, 32'hffff_ffff);
        cycles(10);
        check_out({2'h3, 6'h00});
        ahb(1'b1, REG_CTRL, 32'h0000_0000);
        overtemp_error <= 1'b0;
        cycles(12);
        check_out({2'h1, 6'h00});
        {gate_supply_ok, common_supply_ok} <= 2'h3;
        cycles(12);
        check_out({2'h3, 6'h3f});
        for (int i = 0; i < 6; i++) begin
            {gate_supply_ok, common_supply_ok, overtemp_warn, overtemp_error} <= in_tab[i];
            cycles(12);
            check_out({pin_tab[i], {NUM_BRIDGES{pin_tab[i][1]}}});
            read_chk(REG_STATUS, {30'h0, ~pin_tab[i][0], ~pin_tab[i][1]}, 32'h0000_0003);
            {gate_supply_ok, common_supply_ok, overtemp_warn, overtemp_error} <= 4'hc;
            cycles(12);
            check_out({2'h3, 6'h3f});
        end
        ahb(1'b1, 32'h0000_0008, 32'hffff_ffff);
        read_chk(32'h0000_0008, 32'h0000_0000, 32'hffff_ffff);
        read_chk(REG_CTRL, 32'h0000_0000, 32'h0000_0001);
        for (int i = 0; i < 2 * NUM_BRIDGES; i++) begin
            {oc_high, oc_low} <= 12'h001 << i;
            cycles(10);
            check_word({30'h0, current_limit, overload_latch}, 32'h0000_0002);
            {oc_high, oc_low} <= '0;
            cycles(OL_CYC);
        end
        check_word({30'h0, current_limit, overload_latch}, 32'h0000_0000);
        oc_low <= 6'h20;
        cycles(OL_CYC - 8);
        check_word({30'h0, current_limit, overload_latch}, 32'h0000_0002);
        cycles(20);
        check_word({31'h0, overload_latch}, 32'h0000_0001);
        check_out({2'h1, 6'h00});
        oc_low <= '0;
        cycles(30);
        check_out({2'h1, 6'h00});
        ahb(1'b1, REG_CTRL, 32'h0000_0002);
        cycles(30);
        check_out({2'h1, 6'h00});
        read_chk(REG_STATUS, 32'h0000_0001, 32'h0000_0005);
        cycles(HOLD_CYC);
        read_chk(REG_STATUS, 32'h0000_0005, 32'h0000_0005);
        ahb(1'b1, REG_CTRL, 32'h0000_0002);
        cycles(40);
        check_out({2'h3, 6'h3f});
        read_chk(REG_STATUS, 32'h0000_0000, 32'h0000_0003);
        test_done();
    end
endmodule : amp_fault_supervisor_tb
